// *** hdl/uef_pkg.sv ***
// Package for the UART enhanced-feature register bank: map, fields, resets, types
package uef_pkg;

   // Register indexes; the byte address on APB is four times the index
   localparam logic [3:0] UEF_IDX_LINE_CTRL  = 4'h3;
   localparam logic [3:0] UEF_IDX_PRESCALER  = 4'h4;
   localparam logic [3:0] UEF_IDX_RX_COUNT   = 4'h5;
   localparam logic [3:0] UEF_IDX_TX_COUNT   = 4'h6;
   localparam logic [3:0] UEF_IDX_SPECIAL    = 4'h7;
   localparam logic [3:0] UEF_IDX_IDLE_TIME  = 4'h8;
   localparam logic [3:0] UEF_IDX_TXRX_CTRL  = 4'h9;
   localparam logic [3:0] UEF_IDX_UNLOCK     = 4'hd;
   localparam logic [3:0] UEF_IDX_IRQ_STATUS = 4'hf;

   // Key values that open the extended registers
   localparam logic [7:0] UEF_LINE_KEY   = 8'hbf;
   localparam logic [7:0] UEF_UNLOCK_KEY = 8'h5a;

   // Reset values
   localparam logic [7:0] UEF_RST_LINE_CTRL = 8'h00;
   localparam logic [7:0] UEF_RST_PRESCALER = 8'h10;
   localparam logic [7:0] UEF_RST_SPECIAL   = 8'h00;
   localparam logic [7:0] UEF_RST_IDLE_TIME = 8'h00;
   localparam logic [7:0] UEF_RST_TXRX_CTRL = 8'h06;
   localparam logic [7:0] UEF_RST_UNLOCK    = 8'h00;
   localparam logic [7:0] UEF_RST_IRQ       = 8'h00;
   localparam logic [7:0] UEF_RST_COUNT     = 8'h00;

   // Special function control bit positions
   localparam int UEF_SF_FORCE_TX   = 0;
   localparam int UEF_SF_DSR_DTR    = 1;
   localparam int UEF_SF_ACCESS_EN  = 2;
   localparam int UEF_SF_LOOPBACK   = 3;
   localparam int UEF_SF_BURST      = 4;
   localparam int UEF_SF_COUNT_SEL  = 6;
   localparam int UEF_SF_XTAL_FB    = 7;

   // TX/RX control bit positions
   localparam int UEF_TR_IDLE_EN    = 0;
   localparam int UEF_TR_RX_TIMEOUT = 1;
   localparam int UEF_TR_TX_EMPTY   = 2;
   localparam int UEF_TR_XON_INBAND = 3;

   // Interrupt status: bit 0 is the wipe bit
   localparam int UEF_IS_WIPE = 0;

   // Sample-clock base of the baud formula
   localparam logic [5:0] UEF_SAMPLE_BASE = 6'h10;

   // Control levels handed to the UART datapath
   typedef struct packed {
      logic       xtal_fb_disable;
      logic       burst_en;
      logic       loopback_en;
      logic       dsr_dtr_flow_en;
      logic       force_tx;
      logic       idle_insert_en;
      logic [7:0] idle_time;
      logic       xon_inband_en;
      logic       tx_empty_irq_en;
      logic       rx_timeout_en;
   } uef_ctrl_t;

   // FIFO activity pulses from the datapath
   typedef struct packed {
      logic rx_push;
      logic rx_push_err;
      logic rx_pop;
      logic rx_pop_err;
      logic tx_push;
      logic tx_pop;
   } uef_fifo_ev_t;

   // APB slave phase
   typedef enum logic [1:0] {
      UEF_ST_IDLE  = 2'b00,
      UEF_ST_FETCH = 2'b01,
      UEF_ST_DONE  = 2'b11
   } uef_state_t;

endpackage

// *** hdl/uef_regs.sv ***
// UART enhanced-feature register bank with APB slave and baud rate generator
//
// Operation
// (RQ1) Prescaler reachable under key and access-enable; reset 0x10
// (RQ2) Software keeps exponent at 1 or 2
// (RQ3) Baud tick follows divisor, exponent, sample formula
// (RQ4) Counter select picks FIFO or error count
// (RQ5) Receive FIFO byte count, read only
// (RQ6) Line-error byte count, read only, resets zero
// (RQ7) Transmit FIFO byte count under key, access-enable
// (RQ8) Special function reachable under both keys; reset zero
// (RQ9) Access-enable bit opens four extended registers; the code gates six with it
// (RQ10) Burst bit enables burst host access
// (RQ11) Loopback bit loops receive into transmit
// (RQ12) Bit one enables DSR/DTR flow control
// (RQ13) Bit zero forces transmitter always on
// (RQ14) Bit seven disables crystal feedback resistor
// (RQ15) Idle time applies only with idle enable
// (RQ16) Xon, transmit-empty, timeout enables in control
// (RQ17) TX/RX control gated, resets to 0x06
// (RQ18) Software keeps sample and offset values legal
// (RQ19) Status bits seven to one flag events
// (RQ20) Wipe bit clears flags, self-returns to zero
// (RQ21) Software writes unlock key under line key
// (RQ22) Gated-off writes leave registers unchanged
// (RQ23) Counters follow each push or pop
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none

module uef_regs
   import uef_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int DIV_W  = 16
) (
   // Clock and reset
   input  wire logic              clk_sys_i,
   input  wire logic              rst_n_i,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Datapath events and settings
   input  wire uef_fifo_ev_t      fifo_ev_i,
   input  wire logic [7:1]        irq_event_i,
   input  wire logic [DIV_W-1:0]  baud_divisor_i,
   input  wire logic              mode_control_bit7_i,
   // Control towards the datapath
   output uef_ctrl_t              ctrl_o,
   output logic [7:0]             irq_status_o,
   output logic                   baud_tick_o
);

   // Register state
   uef_state_t  state;
   uef_state_t  next_state;
   logic [31:0] next_prdata;
   logic        err_q;
   logic        next_err_q;
   logic [7:0]  line_control_register;
   logic [7:0]  next_line_control_register;
   logic [7:0]  feature_unlock_key;
   logic [7:0]  next_feature_unlock_key;
   logic [7:0]  baud_prescaler;
   logic [7:0]  next_baud_prescaler;
   logic [7:0]  special_function_control;
   logic [7:0]  next_special_function_control;
   logic [7:0]  transmit_idle_time;
   logic [7:0]  next_transmit_idle_time;
   logic [7:0]  tx_rx_control;
   logic [7:0]  next_tx_rx_control;
   logic [7:0]  interrupt_status_clear;
   logic [7:0]  next_interrupt_status_clear;
   logic [7:0]  rx_fifo_count;
   logic [7:0]  next_rx_fifo_count;
   logic [7:0]  rx_line_error_count;
   logic [7:0]  next_rx_line_error_count;
   logic [7:0]  tx_fifo_count;
   logic [7:0]  next_tx_fifo_count;

   // Baud generator state
   logic [31:0] pre_cnt;
   logic [31:0] next_pre_cnt;
   logic [5:0]  smp_cnt;
   logic [5:0]  next_smp_cnt;
   logic        next_baud_tick;

   // Decode helpers
   logic [3:0]  idx;
   logic        line_key_ok;
   logic        ext_ok;
   logic        sf_ok;
   logic        wr_commit;
   logic [7:0]  wbyte;

   // Known register index; unaligned addresses never match
   function automatic logic idx_mapped(input logic [ADDR_W-1:0] a);
      logic [3:0] i;
      i = a[5:2];
      if (a[1:0] != 2'b00 || a[ADDR_W-1:6] != '0) begin
         return 1'b0;
      end else if (i == UEF_IDX_LINE_CTRL || i == UEF_IDX_PRESCALER || i == UEF_IDX_RX_COUNT) begin
         return 1'b1;
      end else if (i == UEF_IDX_TX_COUNT || i == UEF_IDX_SPECIAL || i == UEF_IDX_IDLE_TIME) begin
         return 1'b1;
      end else if (i == UEF_IDX_TXRX_CTRL || i == UEF_IDX_UNLOCK || i == UEF_IDX_IRQ_STATUS) begin
         return 1'b1;
      end else begin
         return 1'b0;
      end
   endfunction

   // Up/down byte counter that saturates instead of wrapping
   function automatic logic [7:0] count_step(input logic [7:0] c, input logic up, input logic dn);
      if (up && !dn && c != 8'hff) begin
         return c + 8'h01;
      end else if (dn && !up && c != 8'h00) begin
         return c - 8'h01;
      end else begin
         return c;
      end
   endfunction

   // Access gating shared by reads and writes
   assign idx         = paddr[5:2];
   assign line_key_ok = (line_control_register == UEF_LINE_KEY);
   assign ext_ok      = line_key_ok && special_function_control[UEF_SF_ACCESS_EN]; // [RQ9]
   assign sf_ok       = line_key_ok && (feature_unlock_key == UEF_UNLOCK_KEY);   // [RQ8]
   assign wr_commit   = psel && penable && pwrite && (state == UEF_ST_DONE) && idx_mapped(paddr);
   assign wbyte       = pwdata[7:0];

   // APB phase: two wait states so read data comes from a flip-flop
   always_comb begin
      next_state  = state;
      next_prdata = prdata;
      next_err_q  = err_q;
      case (state)
         UEF_ST_IDLE: begin
            if (psel && penable) begin
               next_state = UEF_ST_FETCH;
            end
         end
         UEF_ST_FETCH: begin
            next_state  = UEF_ST_DONE;
            next_err_q  = !idx_mapped(paddr);
            next_prdata = 32'h0000_0000;
            if (!pwrite && idx_mapped(paddr)) begin
               if (idx == UEF_IDX_LINE_CTRL) begin
                  next_prdata[7:0] = line_control_register;
               end else if (idx == UEF_IDX_UNLOCK && line_key_ok) begin
                  next_prdata[7:0] = feature_unlock_key;
               end else if (idx == UEF_IDX_PRESCALER && ext_ok) begin
                  next_prdata[7:0] = baud_prescaler;                                  // [RQ1]
               end else if (idx == UEF_IDX_RX_COUNT && ext_ok) begin
                  next_prdata[7:0] = special_function_control[UEF_SF_COUNT_SEL] ?
                                     rx_line_error_count : rx_fifo_count;            // [RQ4]
               end else if (idx == UEF_IDX_TX_COUNT && ext_ok) begin
                  next_prdata[7:0] = tx_fifo_count;                                   // [RQ7]
               end else if (idx == UEF_IDX_SPECIAL && sf_ok) begin
                  next_prdata[7:0] = special_function_control;
               end else if (idx == UEF_IDX_IDLE_TIME && ext_ok) begin
                  next_prdata[7:0] = transmit_idle_time;
               end else if (idx == UEF_IDX_TXRX_CTRL && ext_ok) begin
                  next_prdata[7:0] = tx_rx_control;
               end else if (idx == UEF_IDX_IRQ_STATUS && ext_ok) begin
                  next_prdata[7:0] = interrupt_status_clear;
               end
            end
         end
         UEF_ST_DONE: begin
            next_state = UEF_ST_IDLE;
         end
         default: begin
            next_state = UEF_ST_IDLE;
         end
      endcase
   end

   // Handshake outputs are combinational from the phase
   assign pready  = psel && penable && (state == UEF_ST_DONE);
   assign pslverr = pready && err_q;

   // Writable registers; a write where the gate is shut changes nothing
   always_comb begin
      next_line_control_register    = line_control_register;
      next_feature_unlock_key       = feature_unlock_key;
      next_baud_prescaler           = baud_prescaler;
      next_special_function_control = special_function_control;
      next_transmit_idle_time       = transmit_idle_time;
      next_tx_rx_control            = tx_rx_control;
      if (wr_commit) begin
         if (idx == UEF_IDX_LINE_CTRL) begin
            next_line_control_register = wbyte;
         end else if (idx == UEF_IDX_UNLOCK && line_key_ok) begin
            next_feature_unlock_key = wbyte;
         end else if (idx == UEF_IDX_PRESCALER && ext_ok) begin
            next_baud_prescaler = wbyte;                                               // [RQ1] [RQ22]
         end else if (idx == UEF_IDX_SPECIAL && sf_ok) begin
            next_special_function_control = wbyte;                                     // [RQ8] [RQ22]
         end else if (idx == UEF_IDX_IDLE_TIME && ext_ok) begin
            next_transmit_idle_time = wbyte;                                           // [RQ22]
         end else if (idx == UEF_IDX_TXRX_CTRL && ext_ok) begin
            next_tx_rx_control = wbyte;                                                // [RQ17] [RQ22]
         end
      end
   end

   // Sticky event flags; a new event beats the wipe in the same cycle
   always_comb begin
      next_interrupt_status_clear = interrupt_status_clear;
      if (wr_commit && idx == UEF_IDX_IRQ_STATUS && ext_ok && wbyte[UEF_IS_WIPE]) begin
         next_interrupt_status_clear = UEF_RST_IRQ;                                    // [RQ20]
      end
      next_interrupt_status_clear[7:1] = next_interrupt_status_clear[7:1] | irq_event_i; // [RQ19]
      next_interrupt_status_clear[UEF_IS_WIPE] = 1'b0;                                 // [RQ20]
   end

   // Occupancy counters track each push below 0xff and each pop above 0x00 within one clock
   always_comb begin
      next_rx_fifo_count       = count_step(rx_fifo_count, fifo_ev_i.rx_push, fifo_ev_i.rx_pop);   // [RQ5] [RQ23]
      next_rx_line_error_count = count_step(rx_line_error_count,
                                            fifo_ev_i.rx_push && fifo_ev_i.rx_push_err,
                                            fifo_ev_i.rx_pop && fifo_ev_i.rx_pop_err);            // [RQ6] [RQ23]
      next_tx_fifo_count       = count_step(tx_fifo_count, fifo_ev_i.tx_push, fifo_ev_i.tx_pop);   // [RQ7] [RQ23]
   end

   // Baud generator terms
   logic [4:0]  exp_raw;
   logic [4:0]  exp_eff;
   logic [31:0] pre_top;
   logic [5:0]  smp_top;

   // Exponent M+2*mcr7-1, floored at zero since a negative power has no divider form
   assign exp_raw = {1'b0, baud_prescaler[7:4]} + (mode_control_bit7_i ? 5'h02 : 5'h00);   // [RQ3]
   assign exp_eff = (exp_raw == 5'h00) ? 5'h00 : exp_raw - 5'h01;
   assign pre_top = {{(32 - DIV_W){1'b0}}, baud_divisor_i} << exp_eff;                     // [RQ3]
   assign smp_top = UEF_SAMPLE_BASE - {2'b00, tx_rx_control[7:4]} + {2'b00, baud_prescaler[3:0]}; // [RQ3]

   // Two chained counters: prescaled unit, then sample-clock units per tick
   always_comb begin
      next_pre_cnt   = pre_cnt;
      next_smp_cnt   = smp_cnt;
      next_baud_tick = 1'b0;
      if (pre_top == 32'h0000_0000 || smp_top == 6'h00) begin
         next_pre_cnt = 32'h0000_0000;  // Divisor zero stops the generator
         next_smp_cnt = 6'h00;
      end else if (pre_cnt >= pre_top - 32'h0000_0001) begin
         next_pre_cnt = 32'h0000_0000;
         if (smp_cnt >= smp_top - 6'h01) begin
            next_smp_cnt   = 6'h00;
            next_baud_tick = 1'b1;                                                     // [RQ3]
         end else begin
            next_smp_cnt = smp_cnt + 6'h01;
         end
      end else begin
         next_pre_cnt = pre_cnt + 32'h0000_0001;
      end
   end

   // Single register stage for all state
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         state                    <= UEF_ST_IDLE;
         prdata                   <= 32'h0000_0000;
         err_q                    <= 1'b0;
         line_control_register    <= UEF_RST_LINE_CTRL;
         feature_unlock_key       <= UEF_RST_UNLOCK;
         baud_prescaler           <= UEF_RST_PRESCALER;                                // [RQ1]
         special_function_control <= UEF_RST_SPECIAL;                                  // [RQ8]
         transmit_idle_time       <= UEF_RST_IDLE_TIME;
         tx_rx_control            <= UEF_RST_TXRX_CTRL;                                // [RQ17]
         interrupt_status_clear   <= UEF_RST_IRQ;
         rx_fifo_count            <= UEF_RST_COUNT;
         rx_line_error_count      <= UEF_RST_COUNT;                                    // [RQ6]
         tx_fifo_count            <= UEF_RST_COUNT;
         pre_cnt                  <= 32'h0000_0000;
         smp_cnt                  <= 6'h00;
         baud_tick_o              <= 1'b0;
      end else begin
         state                    <= next_state;
         prdata                   <= next_prdata;
         err_q                    <= next_err_q;
         line_control_register    <= next_line_control_register;
         feature_unlock_key       <= next_feature_unlock_key;
         baud_prescaler           <= next_baud_prescaler;
         special_function_control <= next_special_function_control;
         transmit_idle_time       <= next_transmit_idle_time;
         tx_rx_control            <= next_tx_rx_control;
         interrupt_status_clear   <= next_interrupt_status_clear;
         rx_fifo_count            <= next_rx_fifo_count;
         rx_line_error_count      <= next_rx_line_error_count;
         tx_fifo_count            <= next_tx_fifo_count;
         pre_cnt                  <= next_pre_cnt;
         smp_cnt                  <= next_smp_cnt;
         baud_tick_o              <= next_baud_tick;
      end
   end

   // Control levels straight from register bits, except idle time gated by idle enable
   assign ctrl_o.xtal_fb_disable = special_function_control[UEF_SF_XTAL_FB];          // [RQ14]
   assign ctrl_o.burst_en        = special_function_control[UEF_SF_BURST];            // [RQ10]
   assign ctrl_o.loopback_en     = special_function_control[UEF_SF_LOOPBACK];         // [RQ11]
   assign ctrl_o.dsr_dtr_flow_en = special_function_control[UEF_SF_DSR_DTR];          // [RQ12]
   assign ctrl_o.force_tx        = special_function_control[UEF_SF_FORCE_TX];         // [RQ13]
   assign ctrl_o.idle_insert_en  = tx_rx_control[UEF_TR_IDLE_EN];                     // [RQ15]
   // Idle interval reads as zero unless insertion is on, so the datapath cannot misuse it
   assign ctrl_o.idle_time       = tx_rx_control[UEF_TR_IDLE_EN] ? transmit_idle_time : 8'h00; // [RQ15]
   assign ctrl_o.xon_inband_en   = tx_rx_control[UEF_TR_XON_INBAND];                  // [RQ16]
   assign ctrl_o.tx_empty_irq_en = tx_rx_control[UEF_TR_TX_EMPTY];                    // [RQ16]
   assign ctrl_o.rx_timeout_en   = tx_rx_control[UEF_TR_RX_TIMEOUT];                  // [RQ16]
   assign irq_status_o           = interrupt_status_clear;

endmodule

`default_nettype wire

// *** tb/uef_regs_props.sv ***
// Assertion checker for the enhanced-feature register bank ports
`timescale 1ns/1ps
`default_nettype none
module uef_regs_props
   import uef_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int DIV_W  = 16
) (
   // Clock and reset
   input wire logic              clk_sys_i,
   input wire logic              rst_n_i,
   // APB
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   // Datapath side
   input wire logic [7:1]        irq_event_i,
   input wire logic [DIV_W-1:0]  baud_divisor_i,
   input wire uef_ctrl_t         ctrl_o,
   input wire logic [7:0]        irq_status_o,
   input wire logic              baud_tick_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);

   // Bus handshake: two wait states, answer only inside an access
   a_two_waits: assert property ($rose(penable) |-> !pready ##1 !pready ##1 pready)
      else $error("pready not on third access cycle");
   a_ready_access: assert property (pready |-> psel && penable)
      else $error("pready outside access phase");
   // Refusal exactly for misaligned, out-of-range or unmapped places
   a_err_map: assert property (pready |-> pslverr == (paddr[1:0] != 2'h0 || paddr[ADDR_W-1:6] != 0 ||
      paddr[5:2] inside {4'h0, 4'h1, 4'h2, 4'ha, 4'hb, 4'hc, 4'he}))
      else $error("pslverr wrong for address");
   a_rd_hold: assert property (!(psel && penable) |=> $stable(prdata))
      else $error("prdata moved outside a transfer");
   a_rd_upper: assert property (prdata[31:8] == 24'h0)
      else $error("prdata upper bits set");
   // Flags latch every event; only a wipe write can drop them
   a_irq_set: assert property ((|irq_event_i) |=>
      (irq_status_o[7:1] & $past(irq_event_i)) == $past(irq_event_i))
      else $error("event did not set its flag");
   a_irq_wipe: assert property ((($past(irq_status_o[7:1]) & ~irq_status_o[7:1]) != 7'h0) |->
      $past(pready && pwrite && pwdata[0] && paddr[5:2] == 4'hf))
      else $error("flag dropped without wipe");
   a_wipe_self: assert property (irq_status_o[0] == 1'b0)
      else $error("wipe bit reads as set");
   a_idle_gate: assert property (!ctrl_o.idle_insert_en |-> ctrl_o.idle_time == 8'h00)
      else $error("idle time passed while disabled");
   // Tick is a lone pulse for divisors above one and stops with a zero divisor
   a_tick_single: assert property (baud_tick_o && baud_divisor_i > 1 |=> !baud_tick_o)
      else $error("baud tick longer than one cycle");
   a_tick_stop: assert property (baud_divisor_i == 0 && $past(baud_divisor_i) == 0 |-> !baud_tick_o)
      else $error("baud tick with zero divisor");
endmodule

bind uef_regs uef_regs_props #(.ADDR_W(ADDR_W), .DIV_W(DIV_W)) i_props (
   .clk_sys_i, .rst_n_i, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .irq_event_i, .baud_divisor_i, .ctrl_o, .irq_status_o, .baud_tick_o);
`default_nettype wire

// *** tb/uef_apb_host.sv ***
// Host processor model: APB master issuing one transfer at a time
`timescale 1ns/1ps
`default_nettype none
module uef_apb_host (
   // Clock
   input  wire logic        clk_sys_i,
   // APB master outputs
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   // APB answers
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   // Idle bus from time zero so reset sees no request
   initial {psel, penable, pwrite, paddr, pwdata} = '0;

   // Called just after an edge; request held until pready sampled high
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys_i);
      penable <= 1'b1;
      do @(posedge clk_sys_i); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Idle edge between transfers
      @(posedge clk_sys_i);
   endtask
endmodule
`default_nettype wire

// *** tb/uef_regs_tb.sv ***
// Self-checking bench for the enhanced-feature register bank
`timescale 1ns/1ps
`default_nettype none
module uef_regs_tb;
   import uef_pkg::*;
   logic         clk_sys_i = 1'b0;
   logic         rst_n_i = 1'b0;
   logic         psel, penable, pwrite, pready, pslverr, err, baud_tick_o;
   logic [7:0]   paddr, irq_status_o;
   logic [31:0]  pwdata, prdata, rd;
   uef_fifo_ev_t fifo_ev_i = '0;
   logic [7:1]   irq_event_i = 7'h00;
   logic [15:0]  baud_divisor_i = 16'h0000;
   logic         mode_control_bit7_i = 1'b0;
   uef_ctrl_t    ctrl_o, exp_ctrl;
   int           error_cnt = 0, total_checks = 0, cyc = 0, seed = 55654;
   int           line = 0, unl = 0, sf = 0, pre = 8'h10, idl = 0, trc = 8'h06, irq = 0;
   int           rxc = 0, erc = 0, txc = 0, r, n, ph;
   int           per[3] = '{32, 128, 60};
   logic [7:0]   pv[3] = '{8'h10, 8'h10, 8'h22};
   logic [7:0]   tv[3] = '{8'h06, 8'h06, 8'h36};

   uef_regs #(.ADDR_W(8), .DIV_W(16)) i_dut (
      .clk_sys_i, .rst_n_i, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .fifo_ev_i, .irq_event_i, .baud_divisor_i, .mode_control_bit7_i, .ctrl_o, .irq_status_o, .baud_tick_o);
   uef_apb_host i_host (
      .clk_sys_i, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

   // 10 MHz clock; cycle ceiling far above the run
   always #50 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      if (error_cnt == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask

   function automatic logic bad_addr(input logic [7:0] a);
      return a[1:0] || a[7:6] || a[5:2] inside {4'h0, 4'h1, 4'h2, 4'ha, 4'hb, 4'hc, 4'he};
   endfunction

   // Saturating byte counter; push and pop together leave it
   function automatic int stp(input int c, input logic u, input logic d);
      return (u && !d && c < 255) ? c + 1 : (d && !u && c > 0) ? c - 1 : c;
   endfunction

   // Reference read; gated places read zero
   function automatic logic [7:0] model_rd(input logic [3:0] i);
      logic k, a;
      k = (line == UEF_LINE_KEY);
      a = k && sf[2];
      case (i)
         4'h3: return 8'(line);
         4'h4: return a ? 8'(pre) : 8'h00;
         4'h5: return a ? 8'(sf[6] ? erc : rxc) : 8'h00;
         4'h6: return a ? 8'(txc) : 8'h00;
         4'h7: return (k && unl == UEF_UNLOCK_KEY) ? 8'(sf) : 8'h00;
         4'h8: return a ? 8'(idl) : 8'h00;
         4'h9: return a ? 8'(trc) : 8'h00;
         4'hd: return k ? 8'(unl) : 8'h00;
         4'hf: return a ? 8'(irq) : 8'h00;
         default: return 8'h00;
      endcase
   endfunction

   task automatic model_wr(input logic [3:0] i, input logic [7:0] d);
      logic k, a;
      k = (line == UEF_LINE_KEY);
      a = k && sf[2];
      if (i == 4'h3) line = d;
      if (i == 4'hd && k) unl = d;
      if (i == 4'h7 && k && unl == UEF_UNLOCK_KEY) sf = d;
      if (i == 4'h4 && a) pre = d;
      if (i == 4'h8 && a) idl = d;
      if (i == 4'h9 && a) trc = d;
      if (i == 4'hf && a && d[0]) irq = 0;
   endtask

   // One transfer, checked against the reference
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
      logic [7:0] e;
      e = model_rd(a[5:2]);
      i_host.xfer(wr, a, {24'h0, d}, rd, err);
      check("pslverr", 32'(err), 32'(bad_addr(a)));
      if (!wr) check("prdata", rd, bad_addr(a) ? 32'h0 : {24'h0, e});
      else if (!bad_addr(a)) model_wr(a[5:2], d);
      exp_ctrl = {sf[7], sf[4], sf[3], sf[1], sf[0], trc[0], trc[0] ? 8'(idl) : 8'h00, trc[3], trc[2], trc[1]};
      check("ctrl_o", 32'(ctrl_o), 32'(exp_ctrl));
      check("irq_status_o", 32'(irq_status_o), 32'(irq));
   endtask

   initial begin
      repeat (5) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      @(posedge clk_sys_i);
      // Without keys only the line register shows; unaligned access refused
      for (n = 0; n < 16; n++) bus(1'b0, 8'(n * 4), 8'h00);
      bus(1'b0, 8'h11, 8'h00);
      for (n = 4; n < 16; n++) bus(1'b1, 8'(n * 4), 8'hff);
      bus(1'b1, 8'h0c, UEF_LINE_KEY);
      bus(1'b1, 8'h34, UEF_UNLOCK_KEY);
      bus(1'b1, 8'h1c, 8'h04);
      // Reset values now visible
      for (n = 0; n < 16; n++) bus(1'b0, 8'(n * 4), 8'h00);
      // Random mix keeps the line key, may relock special
      for (n = 0; n < 80; n++) begin
         r = $random(seed);
         bus(r[8], {2'b00, (r[3:0] == 4'h3) ? 4'h4 : r[3:0], 2'b00}, r[23:16]);
      end
      bus(1'b1, 8'h34, UEF_UNLOCK_KEY);
      bus(1'b1, 8'h1c, 8'h04);
      // Fill, then drain; counts read in both selections
      for (ph = 0; ph < 2; ph++) begin
         for (n = 0; n < 300; n++) begin
            r = $random(seed);
            fifo_ev_i.rx_push <= (ph == 0) | (r[5] & r[6]);
            fifo_ev_i.rx_pop <= (ph == 1) | (r[3] & r[6]);
            fifo_ev_i.rx_push_err <= r[4];
            fifo_ev_i.rx_pop_err <= r[2];
            fifo_ev_i.tx_push <= r[1];
            fifo_ev_i.tx_pop <= r[0];
            @(posedge clk_sys_i);
            rxc = stp(rxc, fifo_ev_i.rx_push, fifo_ev_i.rx_pop);
            erc = stp(erc, fifo_ev_i.rx_push & fifo_ev_i.rx_push_err, fifo_ev_i.rx_pop & fifo_ev_i.rx_pop_err);
            txc = stp(txc, fifo_ev_i.tx_push, fifo_ev_i.tx_pop);
         end
         fifo_ev_i <= '0;
         bus(1'b0, 8'h14, 8'h00);
         bus(1'b0, 8'h18, 8'h00);
         bus(1'b1, 8'h1c, 8'h44);
         bus(1'b0, 8'h14, 8'h00);
         bus(1'b1, 8'h1c, 8'h04);
      end
      // Flags latch, ignore writes to the flag bits, and clear on wipe
      repeat (4) begin
         r = $random(seed);
         irq_event_i <= r[7:1];
         @(posedge clk_sys_i);
         irq_event_i <= 7'h00;
         irq = irq | {r[7:1], 1'b0};
         bus(1'b0, 8'h3c, 8'h00);
         bus(1'b1, 8'h3c, 8'hfe);
         bus(1'b1, 8'h3c, 8'h01);
         bus(1'b0, 8'h3c, 8'h00);
      end
      // Baud period for a table of settings
      for (n = 0; n < 3; n++) begin
         bus(1'b1, 8'h10, pv[n]);
         bus(1'b1, 8'h24, tv[n]);
         mode_control_bit7_i <= (n == 1);
         baud_divisor_i <= 16'h0002;
         repeat (2) do @(posedge clk_sys_i); while (baud_tick_o !== 1'b1);
         r = 0;
         do begin
            @(posedge clk_sys_i);
            r++;
         end while (baud_tick_o !== 1'b1);
         check("baud period", 32'(r), 32'(per[n]));
      end
      baud_divisor_i <= 16'h0000;
      repeat (50) @(posedge clk_sys_i);
      print_verdict();
   end
endmodule
`default_nettype wire
